// >>> bridge_cmd_cfg.svh
`ifndef BRIDGE_CMD_CFG_SVH
`define BRIDGE_CMD_CFG_SVH

// =====================================================================
// bus command encodings on the command/byte-enable lanes
`define CMD_INT_ACK      4'h0
`define CMD_SPECIAL      4'h1
`define CMD_IO_RD        4'h2
`define CMD_IO_WR        4'h3
`define CMD_MEM_RD       4'h6
`define CMD_MEM_WR       4'h7
`define CMD_CFG_RD       4'hA
`define CMD_CFG_WR       4'hB
`define CMD_MEM_RD_MULT  4'hC
`define CMD_DUAL_ADDR    4'hD
`define CMD_MEM_RD_LINE  4'hE
`define CMD_MEM_WR_INV   4'hF

// =====================================================================
// configuration address field positions
`define CFG_TYPE_MSB     1
`define CFG_TYPE_LSB     0
`define CFG_TYPE0        2'h0
`define CFG_TYPE1        2'h1
`define CFG_BUS_MSB      23
`define CFG_BUS_LSB      16
`define CFG_DEV_MSB      15
`define CFG_DEV_LSB      11
`define CFG_FUNC_MSB     10
`define CFG_FUNC_LSB     8

// =====================================================================
// special cycle request signature and reset values
`define SPECIAL_DEV      5'h1F
`define SPECIAL_FUNC     3'h7
`define NUM_FUNCS_DEF    4'h1
`define CMD_RESET        4'h0

`endif

// >>> bridge_cmd_pkg.sv
package bridge_cmd_pkg;

   // decode outcome for one address phase
   typedef enum logic [2:0]
   {
      ACT_IGNORE   = 3'h0,
      ACT_INTERNAL = 3'h1,
      ACT_FORWARD  = 3'h2,
      ACT_TYPE0    = 3'h3,
      ACT_SPECIAL  = 3'h4
   } action_t;

   // address phase tracking: second phase follows a dual address cycle
   typedef enum logic
   {
      PH_ADDR = 1'b0,
      PH_HIGH = 1'b1
   } phase_t;

   // registered result of one side
   typedef struct packed
   {
      phase_t     phase;
      logic       valid;
      logic       claim;
      action_t    act;
      logic [3:0] cmd;
      logic       dual;
   } side_state_t;

endpackage

// >>> cmd_class.sv
`timescale 1ns/1ps
`include "bridge_cmd_cfg.svh"

// =====================================================================
// command classification, shared by both interfaces
module cmd_class
(
   input  wire logic [3:0] cmd,
   output logic            is_io,
   output logic            is_mem,
   output logic            is_cfg_rd,
   output logic            is_cfg_wr,
   output logic            is_dual
);

   // read-multiple, read-line and write-invalidate decode like memory
   always_comb
   begin
      is_io     = (cmd == `CMD_IO_RD) || (cmd == `CMD_IO_WR);
      is_mem    = (cmd == `CMD_MEM_RD) || (cmd == `CMD_MEM_WR)
                  || (cmd == `CMD_MEM_RD_MULT)
                  || (cmd == `CMD_MEM_RD_LINE)
                  || (cmd == `CMD_MEM_WR_INV);
      is_cfg_rd = (cmd == `CMD_CFG_RD);
      is_cfg_wr = (cmd == `CMD_CFG_WR);
      is_dual   = (cmd == `CMD_DUAL_ADDR);
   end

endmodule

// >>> bus_match.sv
`timescale 1ns/1ps

// =====================================================================
// bus number comparisons against the programmed bus numbers
module bus_match
(
   input  wire logic [7:0] target_bus,
   input  wire logic [7:0] primary_bus,
   input  wire logic [7:0] secondary_bus,
   input  wire logic [7:0] subordinate_bus,
   output logic            is_pri,
   output logic            is_sec,
   output logic            in_range,
   output logic            is_deeper
);

   // range behind the bridge is secondary..subordinate inclusive
   always_comb
   begin
      is_pri    = (target_bus == primary_bus);
      is_sec    = (target_bus == secondary_bus);
      in_range  = (target_bus >= secondary_bus)
                  && (target_bus <= subordinate_bus);
      is_deeper = in_range && !is_sec;
   end

endmodule

// >>> bridge_command_decode.sv
// Functional notes
// - primary type 1 config read to secondary bus: claim, issue as type 0
// - primary type 1 read to deeper subordinate bus: forward as type 1
// - primary type 1 write: type 0 on secondary, unchanged deeper, else ignore
// - primary type 0 config write claimed exactly like type 0 read
// - primary special request: special cycle on secondary, type 1 deeper
// - read multiple, read line, write invalidate decode like memory read
// - dual address cycle accepted on both interfaces for 64-bit addresses
// - secondary interrupt acknowledge ignored, special cycle never claimed
// - secondary io and memory commands use window based claim and forward
// - secondary config reads, type 0 and plain type 1 writes ignored
// - secondary special request to primary bus makes primary special cycle
// - secondary special request outside all known buses forwarded as type 1
// - secondary special request inside secondary..subordinate range ignored
// - primary type 0 claimed only with select and existing function, internal
// - primary io and memory claimed only inside pass-through windows
`timescale 1ns/1ps
`include "bridge_cmd_cfg.svh"

module bridge_command_decode
#(
   parameter logic [3:0] NUM_FUNCS = `NUM_FUNCS_DEF
)
(
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   // programmed bus numbers
   input  wire logic [7:0]                 primary_bus,
   input  wire logic [7:0]                 secondary_bus,
   input  wire logic [7:0]                 subordinate_bus,
   // primary address phase
   input  wire logic                       p_addr_valid,
   input  wire logic [3:0]                 primary_cmd_lanes,
   input  wire logic [31:0]                p_addr,
   input  wire logic                       p_idsel,
   input  wire logic                       p_io_hit,
   input  wire logic                       p_mem_hit,
   input  wire logic                       p_mmio_hit,
   // secondary address phase
   input  wire logic                       s_addr_valid,
   input  wire logic [3:0]                 secondary_cmd_lanes,
   input  wire logic [31:0]                s_addr,
   input  wire logic                       s_io_hit,
   input  wire logic                       s_mem_hit,
   // primary decode result
   output bridge_cmd_pkg::action_t         p_action,
   output logic                            p_dec_valid,
   output logic                            p_claim,
   output logic [3:0]                      p_fwd_cmd,
   output logic                            p_dual,
   // secondary decode result
   output bridge_cmd_pkg::action_t         s_action,
   output logic                            s_dec_valid,
   output logic                            s_claim,
   output logic [3:0]                      s_fwd_cmd,
   output logic                            s_dual
);
   import bridge_cmd_pkg::*;

   // ==================================================================
   // helpers

   // device 1Fh, function 7h in a type 1 write asks for a special cycle
   function automatic logic is_special_req(input logic [31:0] a);
      is_special_req = (a[`CFG_TYPE_MSB:`CFG_TYPE_LSB] == `CFG_TYPE1)
                       && (a[`CFG_DEV_MSB:`CFG_DEV_LSB] == `SPECIAL_DEV)
                       && (a[`CFG_FUNC_MSB:`CFG_FUNC_LSB] == `SPECIAL_FUNC);
   endfunction

   function automatic logic is_type(input logic [31:0] a,
                                    input logic [1:0]  t);
      is_type = (a[`CFG_TYPE_MSB:`CFG_TYPE_LSB] == t);
   endfunction

   // ==================================================================
   // command classification and bus comparisons

   logic       p_io;
   logic       p_mem;
   logic       p_cfg_rd;
   logic       p_cfg_wr;
   logic       p_dac;
   logic       s_io;
   logic       s_mem;
   logic       s_cfg_wr;
   logic       s_dac;
   logic       p_is_sec;
   logic       p_deeper;
   logic       s_is_pri;
   logic       s_in_range;

   cmd_class u_p_class
   (
      .cmd       (primary_cmd_lanes),
      .is_io     (p_io),
      .is_mem    (p_mem),
      .is_cfg_rd (p_cfg_rd),
      .is_cfg_wr (p_cfg_wr),
      .is_dual   (p_dac)
   );

   cmd_class u_s_class
   (
      .cmd       (secondary_cmd_lanes),
      .is_io     (s_io),
      .is_mem    (s_mem),
      .is_cfg_rd (),
      .is_cfg_wr (s_cfg_wr),
      .is_dual   (s_dac)
   );

   // programmed bus numbers, range inclusive at both ends
   bus_match u_p_bus
   (
      .target_bus      (p_addr[`CFG_BUS_MSB:`CFG_BUS_LSB]),
      .primary_bus     (primary_bus),
      .secondary_bus   (secondary_bus),
      .subordinate_bus (subordinate_bus),
      .is_pri          (),
      .is_sec          (p_is_sec),
      .in_range        (),
      .is_deeper       (p_deeper)
   );

   bus_match u_s_bus
   (
      .target_bus      (s_addr[`CFG_BUS_MSB:`CFG_BUS_LSB]),
      .primary_bus     (primary_bus),
      .secondary_bus   (secondary_bus),
      .subordinate_bus (subordinate_bus),
      .is_pri          (s_is_pri),
      .is_sec          (),
      .in_range        (s_in_range),
      .is_deeper       ()
   );

   // ==================================================================
   // state

   typedef struct packed
   {
      side_state_t p;
      side_state_t s;
   } decode_state_t;

   decode_state_t st_reg;
   decode_state_t st_next;

   logic       p_fn_ok;
   action_t    p_act;
   logic [3:0] p_cmd;
   action_t    s_act;
   logic [3:0] s_cmd;

   // ==================================================================
   // primary decode
   // the three-bit function number is checked against the implemented
   // count; a single-function bridge claims function 0 only
   always_comb
   begin
      p_fn_ok = ({1'b0, p_addr[`CFG_FUNC_MSB:`CFG_FUNC_LSB]} < NUM_FUNCS);
      p_act   = ACT_IGNORE;
      p_cmd   = primary_cmd_lanes;
      if (st_reg.p.phase == PH_HIGH)
      begin
         // second phase of a dual address cycle: memory only
         if (p_mem && (p_mem_hit || p_mmio_hit))
            p_act = ACT_FORWARD;
      end
      else if (p_io)
      begin
         if (p_io_hit)
            p_act = ACT_FORWARD;
      end
      else if (p_mem)
      begin
         if (p_mem_hit || p_mmio_hit)
            p_act = ACT_FORWARD;
      end
      else if ((p_cfg_rd || p_cfg_wr) && is_type(p_addr, `CFG_TYPE0))
      begin
         // own registers only, never forwarded
         if (p_idsel && p_fn_ok)
            p_act = ACT_INTERNAL;
      end
      else if (p_cfg_wr && is_special_req(p_addr))
      begin
         if (p_is_sec)
         begin
            p_act = ACT_SPECIAL;
            p_cmd = `CMD_SPECIAL;
         end
         else if (p_deeper)
            p_act = ACT_FORWARD;
      end
      else if ((p_cfg_rd || p_cfg_wr) && is_type(p_addr, `CFG_TYPE1))
      begin
         if (p_is_sec)
            p_act = ACT_TYPE0;
         else if (p_deeper)
            p_act = ACT_FORWARD;
      end
      // interrupt acknowledge, special cycle and reserved codes fall
      // through as ignore
   end

   // ==================================================================
   // secondary decode
   // upstream windows come from the address-window logic outside
   always_comb
   begin
      s_act = ACT_IGNORE;
      s_cmd = secondary_cmd_lanes;
      if (st_reg.s.phase == PH_HIGH)
      begin
         if (s_mem && s_mem_hit)
            s_act = ACT_FORWARD;
      end
      else if (s_io)
      begin
         if (s_io_hit)
            s_act = ACT_FORWARD;
      end
      else if (s_mem)
      begin
         if (s_mem_hit)
            s_act = ACT_FORWARD;
      end
      else if (s_cfg_wr && is_special_req(s_addr))
      begin
         if (s_is_pri)
         begin
            s_act = ACT_SPECIAL;
            s_cmd = `CMD_SPECIAL;
         end
         else if (!s_in_range)
            s_act = ACT_FORWARD;
         // a bus behind the bridge is ignored
      end
      // config reads, type 0 and plain type 1 writes, interrupt
      // acknowledge, special cycles and reserved codes are ignored
   end

   // ==================================================================
   // next state
   // a dual address phase produces no result itself; the decision is
   // made on the following phase, which carries the real command
   always_comb
   begin
      st_next         = st_reg;
      st_next.p.valid = 1'b0;
      st_next.s.valid = 1'b0;
      if (p_addr_valid)
      begin
         case (st_reg.p.phase)
            PH_ADDR:
            begin
               if (p_dac)
                  st_next.p.phase = PH_HIGH;
               else
               begin
                  st_next.p.valid = 1'b1;
                  st_next.p.act   = p_act;
                  st_next.p.claim = (p_act != ACT_IGNORE);
                  st_next.p.cmd   = p_cmd;
                  st_next.p.dual  = 1'b0;
               end
            end
            PH_HIGH:
            begin
               st_next.p.phase = PH_ADDR;
               st_next.p.valid = 1'b1;
               st_next.p.act   = p_act;
               st_next.p.claim = (p_act != ACT_IGNORE);
               st_next.p.cmd   = p_cmd;
               st_next.p.dual  = 1'b1;
            end
            default:
               st_next.p.phase = PH_ADDR;
         endcase
      end
      if (s_addr_valid)
      begin
         case (st_reg.s.phase)
            PH_ADDR:
            begin
               if (s_dac)
                  st_next.s.phase = PH_HIGH;
               else
               begin
                  st_next.s.valid = 1'b1;
                  st_next.s.act   = s_act;
                  st_next.s.claim = (s_act != ACT_IGNORE);
                  st_next.s.cmd   = s_cmd;
                  st_next.s.dual  = 1'b0;
               end
            end
            PH_HIGH:
            begin
               st_next.s.phase = PH_ADDR;
               st_next.s.valid = 1'b1;
               st_next.s.act   = s_act;
               st_next.s.claim = (s_act != ACT_IGNORE);
               st_next.s.cmd   = s_cmd;
               st_next.s.dual  = 1'b1;
            end
            default:
               st_next.s.phase = PH_ADDR;
         endcase
      end
   end

   // ==================================================================
   // registers
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg.p.phase <= PH_ADDR;
         st_reg.p.valid <= 1'b0;
         st_reg.p.claim <= 1'b0;
         st_reg.p.act   <= ACT_IGNORE;
         st_reg.p.cmd   <= `CMD_RESET;
         st_reg.p.dual  <= 1'b0;
         st_reg.s.phase <= PH_ADDR;
         st_reg.s.valid <= 1'b0;
         st_reg.s.claim <= 1'b0;
         st_reg.s.act   <= ACT_IGNORE;
         st_reg.s.cmd   <= `CMD_RESET;
         st_reg.s.dual  <= 1'b0;
      end
      else
         st_reg <= st_next;
   end

   // outputs straight from the state flops
   assign p_dec_valid = st_reg.p.valid;
   assign p_claim     = st_reg.p.claim;
   assign p_action    = st_reg.p.act;
   assign p_fwd_cmd   = st_reg.p.cmd;
   assign p_dual      = st_reg.p.dual;
   assign s_dec_valid = st_reg.s.valid;
   assign s_claim     = st_reg.s.claim;
   assign s_action    = st_reg.s.act;
   assign s_fwd_cmd   = st_reg.s.cmd;
   assign s_dual      = st_reg.s.dual;

endmodule

// >>> phase_driver.sv
`timescale 1ns/1ps

// =====================================================================
// address phase source standing in for a far-side bus master
module phase_driver
(
   input  wire logic        clk,
   output logic             valid,
   output logic [3:0]       cmd,
   output logic [31:0]      addr,
   output logic             idsel,
   output logic             io_hit,
   output logic             mem_hit,
   output logic             mmio_hit
);
   // quiet lines at time zero
   initial
   begin
      valid = 1'b0;
      cmd = 4'h0;
      addr = 32'h0000_0000;
      {idsel, io_hit, mem_hit, mmio_hit} = 4'h0;
   end

   // one phase per call; released lines flip so stale values never match
   task send(input logic [3:0] c, input logic [31:0] a, input logic [3:0] h);
      @(negedge clk);
      valid = 1'b1;
      cmd = c;
      addr = a;
      {idsel, io_hit, mem_hit, mmio_hit} = h;
      @(negedge clk);
      valid = 1'b0;
      cmd = ~cmd;
      addr = ~addr;
      {idsel, io_hit, mem_hit, mmio_hit} = ~h;
   endtask
endmodule

// >>> bridge_command_decode_props.sv
`timescale 1ns/1ps

// =====================================================================
// decode checker on the top ports
module decode_props
#(
   parameter logic [3:0] NUM_FUNCS = 4'h1
)
(
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic [7:0]           primary_bus,
   input  wire logic [7:0]           secondary_bus,
   input  wire logic                 p_addr_valid,
   input  wire logic [3:0]           primary_cmd_lanes,
   input  wire logic [31:0]          p_addr,
   input  wire logic                 p_idsel,
   input  wire logic                 p_io_hit,
   input  wire logic                 p_mem_hit,
   input  wire logic                 p_mmio_hit,
   input  wire logic                 s_addr_valid,
   input  wire logic [3:0]           secondary_cmd_lanes,
   input  wire logic [31:0]          s_addr,
   input  wire logic                 p_dec_valid,
   input  wire logic                 p_claim,
   input  wire bridge_cmd_pkg::action_t p_action,
   input  wire logic [3:0]           p_fwd_cmd,
   input  wire logic                 s_dec_valid,
   input  wire logic                 s_claim,
   input  wire bridge_cmd_pkg::action_t s_action,
   input  wire logic [3:0]           s_fwd_cmd
);
   import bridge_cmd_pkg::*;
   logic p_wait;
   logic s_wait;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // the phase after a dual phase decodes differently; the dual-pair check needs it, the reserved and ignore-set ones ignore it, the rest skip it
   // and a command in that phase ends the wait whatever its code
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         p_wait <= 1'b0;
         s_wait <= 1'b0;
      end
      else
      begin
         if (p_addr_valid)
            p_wait <= !p_wait && (primary_cmd_lanes == 4'hD);
         if (s_addr_valid)
            s_wait <= !s_wait && (secondary_cmd_lanes == 4'hD);
      end
   end

   sequence p_take(c);
      p_addr_valid && primary_cmd_lanes == c;
   endsequence
   sequence p_mem_phase;
      p_addr_valid && primary_cmd_lanes == 4'h6 && p_mem_hit;
   endsequence
   sequence s_spec_req;
      s_addr_valid && secondary_cmd_lanes == 4'hB && s_addr[1:0] == 2'h1
         && s_addr[15:8] == 8'hFF;
   endsequence

   a_p_dual_pair: assert property (p_mem_phase ##0 p_wait
      |=> p_dec_valid && p_action == ACT_FORWARD && p_fwd_cmd == 4'h6)
      else $error("dual pair not forwarded");
   a_s_dual_quiet: assert property (!s_wait && s_addr_valid &&
      secondary_cmd_lanes == 4'hD |=> !s_dec_valid)
      else $error("secondary dual phase answered");
   a_p_reserved_free: assert property (p_addr_valid &&
      primary_cmd_lanes inside {4'h4, 4'h5, 4'h8, 4'h9} |=> !p_claim)
      else $error("reserved primary command claimed");
   a_s_ignore_set: assert property (s_addr_valid &&
      secondary_cmd_lanes inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA}
      |=> s_dec_valid && !s_claim)
      else $error("secondary command wrongly claimed");
   a_type0_claim: assert property (!p_wait && p_addr_valid &&
      primary_cmd_lanes inside {4'hA, 4'hB} && p_addr[1:0] == 2'h0
      |=> p_claim == ($past(p_idsel) && $past(p_addr[10:8]) < NUM_FUNCS)
      && (!p_claim || p_action == ACT_INTERNAL))
      else $error("type 0 claim wrong");
   a_type1_secbus: assert property (p_take(4'hA) ##0
      (!p_wait && p_addr[1:0] == 2'h1 && p_addr[23:16] == secondary_bus)
      |=> p_action == ACT_TYPE0 && p_fwd_cmd == 4'hA)
      else $error("type 1 read not turned to type 0");
   a_pri_mem_win: assert property (!p_wait && p_addr_valid &&
      primary_cmd_lanes inside {4'h6, 4'h7, 4'hC, 4'hE, 4'hF}
      |=> p_claim == ($past(p_mem_hit) || $past(p_mmio_hit)))
      else $error("memory window claim wrong");
   a_pri_io_win: assert property (!p_wait && p_addr_valid &&
      primary_cmd_lanes inside {4'h2, 4'h3} |=> p_claim == $past(p_io_hit)
      && (!p_claim || p_fwd_cmd == $past(primary_cmd_lanes)))
      else $error("io window claim wrong");
   a_s_spec_pri: assert property (s_spec_req ##0
      (!s_wait && s_addr[23:16] == primary_bus)
      |=> s_action == ACT_SPECIAL && s_fwd_cmd == 4'h1)
      else $error("special request not made special cycle");
endmodule

bind bridge_command_decode decode_props #(.NUM_FUNCS(NUM_FUNCS)) props_inst
(
   .clk, .rst_n, .primary_bus, .secondary_bus, .p_addr_valid,
   .primary_cmd_lanes, .p_addr, .p_idsel, .p_io_hit, .p_mem_hit, .p_mmio_hit,
   .s_addr_valid, .secondary_cmd_lanes, .s_addr, .p_dec_valid, .p_claim,
   .p_action, .p_fwd_cmd, .s_dec_valid, .s_claim, .s_action, .s_fwd_cmd
);

// >>> bridge_command_decode_bench.sv
`timescale 1ns/1ps

`define CHECK(got, exp) \
   begin \
      check_count++; \
      if ((got) !== (exp)) \
      begin \
         failures++; \
         $display("Error at %0t: got %h expected %h", $time, got, exp); \
      end \
   end

module bridge_command_decode_bench;
   import bridge_cmd_pkg::*;
   logic             clk = 1'b0;
   logic             rst_n = 1'b0;
   logic [7:0]       primary_bus = 8'h02;
   logic [7:0]       secondary_bus = 8'h05;
   logic [7:0]       subordinate_bus = 8'h08;
   logic             p_addr_valid, p_idsel, p_io_hit, p_mem_hit, p_mmio_hit;
   logic             s_addr_valid, s_io_hit, s_mem_hit;
   logic [3:0]       primary_cmd_lanes, secondary_cmd_lanes;
   logic [31:0]      p_addr, s_addr;
   action_t          p_action, s_action;
   logic             p_dec_valid, p_claim, p_dual;
   logic             s_dec_valid, s_claim, s_dual;
   logic [3:0]       p_fwd_cmd, s_fwd_cmd;
   int               failures = 0;
   int               check_count = 0;

   always #12.5 clk = ~clk;

   // =====================================================================
   // design and far-side masters
   bridge_command_decode #(.NUM_FUNCS(4'h1)) bridge_command_decode_inst
   (
      .clk, .rst_n, .primary_bus, .secondary_bus, .subordinate_bus,
      .p_addr_valid, .primary_cmd_lanes, .p_addr, .p_idsel, .p_io_hit,
      .p_mem_hit, .p_mmio_hit, .s_addr_valid, .secondary_cmd_lanes, .s_addr,
      .s_io_hit, .s_mem_hit, .p_action, .p_dec_valid, .p_claim, .p_fwd_cmd,
      .p_dual, .s_action, .s_dec_valid, .s_claim, .s_fwd_cmd, .s_dual
   );
   phase_driver pri_drv
   (
      .clk, .valid(p_addr_valid), .cmd(primary_cmd_lanes), .addr(p_addr),
      .idsel(p_idsel), .io_hit(p_io_hit), .mem_hit(p_mem_hit),
      .mmio_hit(p_mmio_hit)
   );
   phase_driver sec_drv
   (
      .clk, .valid(s_addr_valid), .cmd(secondary_cmd_lanes), .addr(s_addr),
      .idsel(), .io_hit(s_io_hit), .mem_hit(s_mem_hit), .mmio_hit()
   );

   // =====================================================================
   // shared helpers; hit bits are {select, io, mem, mmio}
   function automatic logic [31:0] cfg(input logic [7:0] b,
      input logic [4:0] dv, input logic [2:0] f, input logic [1:0] t);
      return {8'h00, b, dv, f, 6'h00, t};
   endfunction

   task chk(input bit s, input logic [3:0] c, input logic [31:0] a,
      input logic [3:0] h, input action_t ea, input logic [3:0] ec,
      input logic d);
      if (s)
         sec_drv.send(c, a, h);
      else
         pri_drv.send(c, a, h);
      if (c == 4'hD)
         `CHECK(s ? s_dec_valid : p_dec_valid, 1'b0)
      else
      begin
         `CHECK(s ? s_dec_valid : p_dec_valid, 1'b1)
         `CHECK(s ? s_action : p_action, ea)
         `CHECK(s ? s_claim : p_claim, ea != ACT_IGNORE)
         `CHECK(s ? s_dual : p_dual, d)
         if (ea > ACT_INTERNAL)
            `CHECK(s ? s_fwd_cmd : p_fwd_cmd, ec)
      end
   endtask

   // =====================================================================
   // scenarios
   task t_pri_cfg;
      chk(0, 4'hA, cfg(8'h00, 5'h00, 3'h0, 2'h0), 4'h8, ACT_INTERNAL, 4'h0, 0);
      chk(0, 4'hA, cfg(8'h00, 5'h00, 3'h0, 2'h0), 4'h0, ACT_IGNORE, 4'h0, 0);
      chk(0, 4'hB, cfg(8'h00, 5'h00, 3'h1, 2'h0), 4'h8, ACT_IGNORE, 4'h0, 0);
      chk(0, 4'hB, cfg(8'h00, 5'h00, 3'h0, 2'h0), 4'h8, ACT_INTERNAL, 4'h0, 0);
      chk(0, 4'hA, cfg(8'h05, 5'h03, 3'h2, 2'h1), 4'h0, ACT_TYPE0, 4'hA, 0);
      chk(0, 4'hA, cfg(8'h08, 5'h03, 3'h2, 2'h1), 4'h0, ACT_FORWARD, 4'hA, 0);
      chk(0, 4'hA, cfg(8'h09, 5'h03, 3'h2, 2'h1), 4'h0, ACT_IGNORE, 4'h0, 0);
      chk(0, 4'hA, cfg(8'h04, 5'h03, 3'h2, 2'h1), 4'h0, ACT_IGNORE, 4'h0, 0);
      chk(0, 4'hB, cfg(8'h05, 5'h03, 3'h2, 2'h1), 4'h0, ACT_TYPE0, 4'hB, 0);
      chk(0, 4'hB, cfg(8'h06, 5'h03, 3'h2, 2'h1), 4'h0, ACT_FORWARD, 4'hB, 0);
      chk(0, 4'hB, cfg(8'h02, 5'h03, 3'h2, 2'h1), 4'h0, ACT_IGNORE, 4'h0, 0);
      chk(0, 4'hB, cfg(8'h05, 5'h1F, 3'h7, 2'h1), 4'h0, ACT_SPECIAL, 4'h1, 0);
      chk(0, 4'hB, cfg(8'h07, 5'h1F, 3'h7, 2'h1), 4'h0, ACT_FORWARD, 4'hB, 0);
      chk(0, 4'hB, cfg(8'h09, 5'h1F, 3'h7, 2'h1), 4'h0, ACT_IGNORE, 4'h0, 0);
      $display("test primary config done");
   endtask

   // memory, io and reserved codes on both sides
   task t_mem_io;
      logic [3:0] mc [5];
      logic [3:0] rc [6];
      mc = '{4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
      rc = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9};
      foreach (mc[i])
      begin
         chk(0, mc[i], 32'h1000_0000, 4'h2, ACT_FORWARD, mc[i], 0);
         chk(0, mc[i], 32'h1000_0000, 4'h1, ACT_FORWARD, mc[i], 0);
         chk(0, mc[i], 32'h1000_0000, 4'h4, ACT_IGNORE, 4'h0, 0);
         chk(1, mc[i], 32'h2000_0000, 4'h2, ACT_FORWARD, mc[i], 0);
         chk(1, mc[i], 32'h2000_0000, 4'h4, ACT_IGNORE, 4'h0, 0);
      end
      for (int i = 2; i < 4; i++)
      begin
         chk(0, i[3:0], 32'h0000_1000, 4'h4, ACT_FORWARD, i[3:0], 0);
         chk(0, i[3:0], 32'h0000_1000, 4'h3, ACT_IGNORE, 4'h0, 0);
         chk(1, i[3:0], 32'h0000_2000, 4'h4, ACT_FORWARD, i[3:0], 0);
         chk(1, i[3:0], 32'h0000_2000, 4'h2, ACT_IGNORE, 4'h0, 0);
      end
      foreach (rc[i])
      begin
         chk(0, rc[i], 32'h1000_0000, 4'hF, ACT_IGNORE, 4'h0, 0);
         chk(1, rc[i], 32'h2000_0000, 4'hF, ACT_IGNORE, 4'h0, 0);
      end
      $display("test memory and io done");
   endtask

   // dual phase gives no answer; the memory phase after it does
   task t_dual;
      for (int s = 0; s < 2; s++)
      begin
         chk(s[0], 4'hD, 32'h0000_0001, 4'h0, ACT_IGNORE, 4'h0, 0);
         chk(s[0], 4'h6, 32'h1000_0000, 4'h2, ACT_FORWARD, 4'h6, 1);
      end
      $display("test dual address done");
   endtask

   task t_sec_cfg;
      chk(1, 4'hA, cfg(8'h05, 5'h03, 3'h0, 2'h1), 4'h0, ACT_IGNORE, 4'h0, 0);
      chk(1, 4'hB, cfg(8'h00, 5'h00, 3'h0, 2'h0), 4'h0, ACT_IGNORE, 4'h0, 0);
      chk(1, 4'hB, cfg(8'h02, 5'h03, 3'h0, 2'h1), 4'h0, ACT_IGNORE, 4'h0, 0);
      chk(1, 4'hB, cfg(8'h02, 5'h1F, 3'h7, 2'h1), 4'h0, ACT_SPECIAL, 4'h1, 0);
      chk(1, 4'hB, cfg(8'h09, 5'h1F, 3'h7, 2'h1), 4'h0, ACT_FORWARD, 4'hB, 0);
      chk(1, 4'hB, cfg(8'h01, 5'h1F, 3'h7, 2'h1), 4'h0, ACT_FORWARD, 4'hB, 0);
      chk(1, 4'hB, cfg(8'h05, 5'h1F, 3'h7, 2'h1), 4'h0, ACT_IGNORE, 4'h0, 0);
      chk(1, 4'hB, cfg(8'h08, 5'h1F, 3'h7, 2'h1), 4'h0, ACT_IGNORE, 4'h0, 0);
      $display("test secondary config done");
   endtask

   // =====================================================================
   // verdict, reached from the main sequence or the watchdog
   task results;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      t_pri_cfg;
      t_mem_io;
      t_dual;
      t_sec_cfg;
      results;
   end

   // about one hundred fifty cycles of traffic; over thirteen times that means a hang
   initial
   begin
      #50000;
      failures++;
      results;
   end
endmodule
